/* File: hw/health_read_pkg.sv */
package health_read_pkg;

  // ==========================================================
  // task-file register indices
  localparam logic [2:0] REG_DATA         = 3'h0;
  localparam logic [2:0] REG_FEATURE_FAULT = 3'h1;
  localparam logic [2:0] REG_BLOCK_COUNT  = 3'h2;
  localparam logic [2:0] REG_LOG_INDEX    = 3'h3;
  localparam logic [2:0] REG_KEY_LOW      = 3'h4;
  localparam logic [2:0] REG_KEY_HIGH     = 3'h5;
  localparam logic [2:0] REG_DRIVE_SELECT = 3'h6;
  localparam logic [2:0] REG_OPCODE_FLAGS = 3'h7;

  // ==========================================================
  // command and signature values
  localparam logic [7:0] OPCODE_HEALTH    = 8'hb0;
  localparam logic [7:0] FEATURE_READ     = 8'hd0;
  localparam logic [7:0] KEY_LOW_VALUE    = 8'h4f;
  localparam logic [7:0] KEY_HIGH_VALUE   = 8'hc2;

  // ==========================================================
  // state_flags, fault_detail and drive_select bit positions
  localparam int BIT_BUSY          = 7;
  localparam int BIT_READY         = 6;
  localparam int BIT_FAULT         = 5;
  localparam int BIT_XFER          = 3;
  localparam int BIT_FAIL_SUMMARY  = 0;
  localparam int BIT_UNFIXABLE     = 6;
  localparam int BIT_ID_MISSING    = 4;
  localparam int BIT_REJECTED      = 2;
  localparam int BIT_DRIVE_SELECT  = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RESET_REG    = 8'h00;
  localparam logic [7:0]  RESET_FLAGS  = 8'h40;
  localparam logic [15:0] RESET_WORD   = 16'h0000;

  // ==========================================================
  // structure layout
  localparam logic [8:0] OFS_OFFLINE_STATUS = 9'd362;
  localparam logic [8:0] OFS_TEST_STATUS    = 9'd363;
  localparam logic [8:0] OFS_TIME_LO        = 9'd364;
  localparam logic [8:0] OFS_TIME_HI        = 9'd365;
  localparam logic [8:0] OFS_OFFLINE_CAP    = 9'd367;
  localparam logic [8:0] OFS_SMART_CAP_LO   = 9'd368;
  localparam logic [8:0] OFS_SMART_CAP_HI   = 9'd369;
  localparam logic [8:0] OFS_ERRLOG_CAP     = 9'd370;
  localparam logic [8:0] OFS_SHORT_POLL     = 9'd372;
  localparam logic [8:0] OFS_EXT_POLL       = 9'd373;
  localparam logic [8:0] OFS_CHECKSUM       = 9'd511;
  localparam logic [7:0] LAST_WORD          = 8'hff;

  // ==========================================================
  // fixed capability bytes
  localparam logic [7:0]  CAP_OFFLINE    = 8'h1b;
  localparam logic [15:0] CAP_SMART      = 16'h0003;
  localparam logic [7:0]  CAP_ERRLOG     = 8'h01;
  localparam logic [7:0]  POLL_SHORT_MIN = 8'h02;
  localparam logic [7:0]  POLL_EXT_MIN   = 8'h1e;

  // ==========================================================
  // off-line status codes
  localparam logic [7:0] OFFLINE_NEVER     = 8'h00;
  localparam logic [7:0] OFFLINE_DONE      = 8'h02;
  localparam logic [7:0] OFFLINE_SUSPENDED = 8'h04;
  localparam logic [7:0] OFFLINE_HOST_COMMAND_REJECTED_FLAG = 8'h05;
  localparam logic [7:0] OFFLINE_FATAL     = 8'h06;
  localparam logic [7:0] OFFLINE_AUTO_BIT  = 8'h80;

  // ==========================================================
  // self-test status codes
  localparam logic [3:0] TEST_PASSED      = 4'h0;
  localparam logic [3:0] TEST_LAST_ERROR  = 4'h7;
  localparam logic [3:0] TEST_RUNNING     = 4'hf;
  localparam logic [3:0] TEST_MAX_TENTHS  = 4'h9;
  localparam logic [15:0] TIME_MIN        = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SUM  = 3'b010,
    ST_XFER = 3'b100
  } phase_t;

endpackage

/* File: hw/health_byte_map.sv */
`timescale 1ns/10ps
`default_nettype none
module health_byte_map
  import health_read_pkg::*;
(
  input  wire logic [8:0]  index,
  input  wire logic [7:0]  offline_status,
  input  wire logic [7:0]  test_status,
  input  wire logic [15:0] offline_seconds,
  input  wire logic [7:0]  checksum,
  output logic      [7:0]  value
);

  // ==========================================================
  // structure byte at an offset, low byte at lower offset
  always_comb
  begin
    case (index)
      OFS_OFFLINE_STATUS: value = offline_status;          // R13
      OFS_TEST_STATUS:    value = test_status;             // R13
      OFS_TIME_LO:        value = offline_seconds[7:0];    // R24
      OFS_TIME_HI:        value = offline_seconds[15:8];   // R24
      OFS_OFFLINE_CAP:    value = CAP_OFFLINE;             // R14
      OFS_SMART_CAP_LO:   value = CAP_SMART[7:0];          // R14
      OFS_SMART_CAP_HI:   value = CAP_SMART[15:8];         // R14
      OFS_ERRLOG_CAP:     value = CAP_ERRLOG;              // R15
      OFS_SHORT_POLL:     value = POLL_SHORT_MIN;          // R14
      OFS_EXT_POLL:       value = POLL_EXT_MIN;            // R14
      OFS_CHECKSUM:       value = checksum;                // R23
      default:            value = 8'h00;                   // R16
    endcase
  end

endmodule // health_byte_map
`default_nettype wire

/* File: hw/health_read_cmd.sv */
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: command is opcode b0h with feature-select d0h already loaded.
// R2: host loads d0h into feature-select before the opcode.
// R3: host loads keys 4fh and c2h; block count and log index ignored.
// R4: with command-block transport set, the command is unsupported.
// R5: host issues only when ready and self-monitoring is enabled.
// R6: success sends exactly one 512-byte structure as pio data-in.
// R7: success clears busy, fault, transfer-request, failure-summary; sets ready.
// R8: abort if unsupported, disabled, or feature or key values wrong.
// R9: every abort sets command-rejected, fault-detail bit 2.
// R10: unfixable data sets bit 6; missing id or bad checksum sets bit 4. Here only ID_MISSING sets bit 4; no checksum error is detected.
// R11: error clears busy and transfer-request, sets ready and fault, summary.
// R12: drive-select bit shows the selected drive in every completion.
// R13: off-line status 362, self-test status 363, seconds at 364-365.
// R14: fixed capabilities at 367, 368-369, polling times at 372, 373.
// R15: byte 370 bit 0 reports error logging, bits 7-1 reserved.
// R16: bytes 374-385 read zero; fixed bytes never change.
// R17: off-line status codes 00, 02, 04, 05, 06 with optional bit 7.
// R18: self-test low nibble is remaining tenths, 0 to 9.
// R19: self-test high nibble 15 while running, 0 when passed or never run.
// R20: status 1 host abort, 2 reset interruption, 3 fatal error.
// R21: failed element 4 unknown, 5 electrical, 6 servo, 7 read.
// R22: off-line completion time lies between 0001h and ffffh.
// R23: byte 511 makes all 512 bytes sum to zero.
// R24: multi-byte fields go least significant byte first.
// R25: an aborted command never raises transfer-request.
module health_read_cmd
  import health_read_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [2:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             BUSY,
  output logic             XFER_REQ,
  input  wire logic        SMART_ENABLED,
  input  wire logic        PACKET_SET,
  input  wire logic        DATA_UNFIXABLE,
  input  wire logic        ID_MISSING,
  input  wire logic        OFFLINE_AUTO,
  input  wire logic [2:0]  OFFLINE_STATE,
  input  wire logic [3:0]  TEST_RESULT,
  input  wire logic [3:0]  TEST_TENTHS,
  input  wire logic [15:0] OFFLINE_SECONDS
);

  // ==========================================================
  // pin synchronisers
  logic [31:0] pin_meta;
  logic [31:0] pin_sync;
  logic [31:0] pin_raw;

  assign pin_raw = {SMART_ENABLED, PACKET_SET, DATA_UNFIXABLE, ID_MISSING,
                    OFFLINE_AUTO, OFFLINE_STATE, TEST_RESULT, TEST_TENTHS,
                    OFFLINE_SECONDS};

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pin_meta <= 32'h00000000;
      pin_sync <= 32'h00000000;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic        smart_on;
  logic        packet_on;
  logic        unfixable;
  logic        id_missing;
  logic        auto_on;
  logic [2:0]  offline_state;
  logic [3:0]  test_result;
  logic [3:0]  test_tenths;
  logic [15:0] seconds_in;

  assign {smart_on, packet_on, unfixable, id_missing, auto_on, offline_state,
          test_result, test_tenths, seconds_in} = pin_sync;

  // ==========================================================
  // field encoders
  function automatic logic [7:0] offline_code(input logic [2:0] st, input logic auto_bit);
    logic [7:0] code;
    case (st)
      3'd1:    code = OFFLINE_DONE;
      3'd2:    code = OFFLINE_SUSPENDED;
      3'd3:    code = OFFLINE_HOST_COMMAND_REJECTED_FLAG;
      3'd4:    code = OFFLINE_FATAL;
      default: code = OFFLINE_NEVER;
    endcase
    return code | (auto_bit ? OFFLINE_AUTO_BIT : 8'h00);
  endfunction

  function automatic logic [7:0] test_code(input logic [3:0] res, input logic [3:0] tenths);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = (res > TEST_LAST_ERROR && res != TEST_RUNNING) ? TEST_PASSED : res;
    lo = (tenths > TEST_MAX_TENTHS) ? TEST_MAX_TENTHS : tenths;
    return {hi, lo};
  endfunction

  // ==========================================================
  // task-file registers
  logic [7:0] feature_select;
  logic [7:0] block_count;
  logic [7:0] log_index;
  logic [7:0] key_low;
  logic [7:0] key_high;
  logic [7:0] drive_select;
  logic [7:0] state_flags;
  logic [7:0] fault_detail;
  phase_t     phase;
  logic       cmd_write;

  assign cmd_write = WR && ADDR == REG_OPCODE_FLAGS && phase == ST_IDLE;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      feature_select <= RESET_REG;
      block_count    <= RESET_REG;
      log_index      <= RESET_REG;
      key_low        <= RESET_REG;
      key_high       <= RESET_REG;
      drive_select   <= RESET_REG;
    end
    else if (WR && phase == ST_IDLE)
    begin
      case (ADDR)
        REG_FEATURE_FAULT: feature_select <= WDATA[7:0];
        REG_BLOCK_COUNT:   block_count    <= WDATA[7:0];
        REG_LOG_INDEX:     log_index      <= WDATA[7:0];
        REG_KEY_LOW:       key_low        <= WDATA[7:0];
        REG_KEY_HIGH:      key_high       <= WDATA[7:0];
        REG_DRIVE_SELECT:  drive_select   <= WDATA[7:0];
        default:           ;
      endcase
    end
  end

  // ==========================================================
  // command decode
  logic reject;
  logic data_fault;

  assign reject = (WDATA[7:0] != OPCODE_HEALTH)            // R1
               || packet_on                                // R4
               || !smart_on                                // R8
               || feature_select != FEATURE_READ           // R8
               || key_low != KEY_LOW_VALUE                 // R8
               || key_high != KEY_HIGH_VALUE;              // R8
  assign data_fault = unfixable || id_missing;             // R10

  // ==========================================================
  // snapshot of variable fields
  logic [7:0]  snap_offline;
  logic [7:0]  snap_test;
  logic [15:0] snap_seconds;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      snap_offline <= RESET_REG;
      snap_test    <= RESET_REG;
      snap_seconds <= TIME_MIN;
    end
    else if (cmd_write)
    begin
      snap_offline <= offline_code(offline_state, auto_on);             // R17
      snap_test    <= test_code(test_result, test_tenths);              // R18 R19 R20 R21
      snap_seconds <= (seconds_in == 16'h0000) ? TIME_MIN : seconds_in; // R22
    end
  end

  // ==========================================================
  // structure bytes of the current word
  logic [7:0] word_index;
  logic [7:0] byte_lo;
  logic [7:0] byte_hi;
  logic [7:0] checksum;
  logic [7:0] sum;

  health_byte_map map_lo (
    .index           ({word_index, 1'b0}),
    .offline_status  (snap_offline),
    .test_status     (snap_test),
    .offline_seconds (snap_seconds),
    .checksum        (checksum),
    .value           (byte_lo)
  );

  health_byte_map map_hi (
    .index           ({word_index, 1'b1}),
    .offline_status  (snap_offline),
    .test_status     (snap_test),
    .offline_seconds (snap_seconds),
    .checksum        (checksum),
    .value           (byte_hi)
  );

  // ==========================================================
  // phase sequencing and checksum
  logic data_read;

  assign data_read = RD && ADDR == REG_DATA && phase == ST_XFER;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      phase      <= ST_IDLE;
      word_index <= 8'h00;
      sum        <= 8'h00;
      checksum   <= 8'h00;
    end
    else
    begin
      case (phase)
        ST_IDLE:
        begin
          word_index <= 8'h00;
          sum        <= 8'h00;
          if (cmd_write && !reject && !data_fault)
            phase <= ST_SUM;                               // R25
        end
        ST_SUM:
        begin
          if (word_index == LAST_WORD)
          begin
            checksum   <= 8'h00 - (sum + byte_lo);         // R23
            word_index <= 8'h00;
            phase      <= ST_XFER;
          end
          else
          begin
            sum        <= sum + byte_lo + byte_hi;         // R23
            word_index <= word_index + 8'h01;
          end
        end
        ST_XFER:
        begin
          if (data_read)
          begin
            word_index <= word_index + 8'h01;
            if (word_index == LAST_WORD)
              phase <= ST_IDLE;                            // R6
          end
        end
        default:
          phase <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // state_flags and fault_detail
  logic [7:0] next_fault;

  always_comb
  begin
    next_fault = 8'h00;
    next_fault[BIT_REJECTED]   = reject;                   // R9
    next_fault[BIT_UNFIXABLE]  = !reject && unfixable;     // R10
    next_fault[BIT_ID_MISSING] = !reject && id_missing;    // R10
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_flags  <= RESET_FLAGS;
      fault_detail <= RESET_REG;
    end
    else if (cmd_write)
    begin
      fault_detail <= next_fault;
      state_flags  <= 8'h00;
      if (reject || data_fault)
      begin
        state_flags[BIT_READY]        <= 1'b1;             // R11
        state_flags[BIT_FAULT]        <= 1'b1;             // R11
        state_flags[BIT_FAIL_SUMMARY] <= |next_fault;      // R11
      end
      else
        state_flags[BIT_BUSY] <= 1'b1;
    end
    else if (phase == ST_SUM && word_index == LAST_WORD)
    begin
      state_flags[BIT_BUSY]  <= 1'b0;
      state_flags[BIT_READY] <= 1'b1;
      state_flags[BIT_XFER]  <= 1'b1;                      // R6
    end
    else if (data_read && word_index == LAST_WORD)
    begin
      state_flags <= 8'h00;                                // R7
      state_flags[BIT_READY] <= 1'b1;                      // R7
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      BUSY     <= 1'b0;
      XFER_REQ <= 1'b0;
    end
    else
    begin
      BUSY     <= phase == ST_SUM;
      XFER_REQ <= phase == ST_XFER && !(data_read && word_index == LAST_WORD); // R25
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge CLK)
  begin
    if (RST)
      RDATA <= RESET_WORD;
    else if (RD)
    begin
      case (ADDR)
        REG_DATA:          RDATA <= (phase == ST_XFER) ? {byte_hi, byte_lo} : RESET_WORD; // R24
        REG_FEATURE_FAULT: RDATA <= {8'h00, fault_detail};
        REG_BLOCK_COUNT:   RDATA <= {8'h00, block_count};
        REG_LOG_INDEX:     RDATA <= {8'h00, log_index};
        REG_KEY_LOW:       RDATA <= {8'h00, key_low};
        REG_KEY_HIGH:      RDATA <= {8'h00, key_high};
        REG_DRIVE_SELECT:  RDATA <= {8'h00, drive_select}; // R12
        REG_OPCODE_FLAGS:  RDATA <= {8'h00, state_flags};
        default:           RDATA <= RESET_WORD;
      endcase
    end
    else
      RDATA <= RESET_WORD;
  end

endmodule // health_read_cmd
`default_nettype wire

/* File: verification/health_read_cmd_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module health_read_cmd_sva
  import health_read_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [2:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        BUSY,
  input wire logic        XFER_REQ,
  input wire logic        SMART_ENABLED,
  input wire logic        PACKET_SET,
  input wire logic        DATA_UNFIXABLE,
  input wire logic        ID_MISSING
);
  // ==========================================================
  // shadow of the signature registers and word counter
  logic [7:0] feat;
  logic [7:0] klo;
  logic [7:0] khi;
  logic [8:0] rd_cnt;
  logic       op_wr;
  logic       cmd_ok;
  assign op_wr  = WR && ADDR == REG_OPCODE_FLAGS && !BUSY && !XFER_REQ;
  assign cmd_ok = WDATA[7:0] == OPCODE_HEALTH && feat == FEATURE_READ && klo == KEY_LOW_VALUE
                  && khi == KEY_HIGH_VALUE && SMART_ENABLED && !PACKET_SET && !DATA_UNFIXABLE && !ID_MISSING;
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      feat <= 8'h00;
      klo  <= 8'h00;
      khi  <= 8'h00;
    end
    else if (WR && !BUSY && !XFER_REQ)
    begin
      if (ADDR == REG_FEATURE_FAULT) feat <= WDATA[7:0];
      if (ADDR == REG_KEY_LOW) klo <= WDATA[7:0];
      if (ADDR == REG_KEY_HIGH) khi <= WDATA[7:0];
    end
  end
  always_ff @(posedge CLK)
  begin
    if (RST || BUSY) rd_cnt <= 9'h000;
    else if (RD && ADDR == REG_DATA && XFER_REQ) rd_cnt <= rd_cnt + 9'h001;
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside read slot");
  AST_REJECT_QUIET: assert property (op_wr && !cmd_ok |=> (!BUSY && !XFER_REQ) [*8])
    else $error("rejected command went busy or requested transfer");
  AST_ACCEPT_BUSY: assert property (op_wr && cmd_ok |-> ##2 BUSY)
    else $error("accepted command did not go busy");
  AST_BUSY_SPAN: assert property ($rose(BUSY) |-> ##[255:257] $fell(BUSY))
    else $error("busy span wrong");
  AST_BUSY_TO_XFER: assert property ($fell(BUSY) |-> XFER_REQ)
    else $error("transfer not requested after busy");
  AST_WORD_COUNT: assert property ($fell(XFER_REQ) |-> rd_cnt == 9'h100)
    else $error("transfer ended after wrong word count");
  AST_EXCLUSIVE: assert property (!(BUSY && XFER_REQ))
    else $error("busy and transfer request together");
  AST_DATA_IDLE_ZERO: assert property (RD && ADDR == REG_DATA && !BUSY && !XFER_REQ |=> RDATA == 16'h0000)
    else $error("data read outside transfer not zero");
  COV_ACCEPT: cover property (op_wr && cmd_ok);
  COV_REJECT: cover property (op_wr && !cmd_ok);
  COV_XFER_END: cover property ($fell(XFER_REQ));
endmodule // health_read_cmd_sva
`default_nettype wire

/* File: verification/health_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module health_host_model
  import health_read_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic [15:0] RDATA,
  output var  logic [2:0]  ADDR,
  output var  logic [15:0] WDATA,
  output var  logic        WR,
  output var  logic        RD
);
  // ==========================================================
  // bus cycles
  initial
  begin
    ADDR  = 3'h0;
    WDATA = 16'h0000;
    WR    = 1'b0;
    RD    = 1'b0;
  end
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask
  // ==========================================================
  // command issue: signature first, opcode last
  task automatic issue(input logic [7:0] f, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] op);
    logic [15:0] s;
    wr(REG_FEATURE_FAULT, {8'h00, f});
    wr(REG_KEY_LOW, {8'h00, lo});
    wr(REG_KEY_HIGH, {8'h00, hi});
    wr(REG_BLOCK_COUNT, 16'h005a);
    for (int i = 0; i < 16; i++)
    begin
      rd(REG_OPCODE_FLAGS, s);
      if (s[BIT_READY] === 1'b1) break;
    end
    wr(REG_OPCODE_FLAGS, {8'h00, op});
  endtask
endmodule // health_host_model
`default_nettype wire

/* File: verification/test_health_read_cmd.sv */
`timescale 1ns/10ps
`default_nettype none
module test_health_read_cmd;
  import health_read_pkg::*;
  logic        CLK, RST, SMART_ENABLED, PACKET_SET, DATA_UNFIXABLE, ID_MISSING, OFFLINE_AUTO;
  logic        WR, RD, BUSY, XFER_REQ;
  logic [2:0]  ADDR, OFFLINE_STATE;
  logic [3:0]  TEST_RESULT, TEST_TENTHS;
  logic [15:0] WDATA, RDATA, OFFLINE_SECONDS, s;
  logic [7:0]  img [512];
  int          err_count, checks, cycles;
  health_read_cmd DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .BUSY(BUSY), .XFER_REQ(XFER_REQ), .SMART_ENABLED(SMART_ENABLED), .PACKET_SET(PACKET_SET),
    .DATA_UNFIXABLE(DATA_UNFIXABLE), .ID_MISSING(ID_MISSING), .OFFLINE_AUTO(OFFLINE_AUTO),
    .OFFLINE_STATE(OFFLINE_STATE), .TEST_RESULT(TEST_RESULT), .TEST_TENTHS(TEST_TENTHS),
    .OFFLINE_SECONDS(OFFLINE_SECONDS));
  health_host_model HOST (.CLK(CLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
  // ==========================================================
  // clock, timeout, reporting
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic checkb(input string name, input int idx, input logic [7:0] exp);
    check(name, {8'h00, img[idx]}, {8'h00, exp});
  endtask
  // ==========================================================
  // aborted command
  task automatic expect_error(input logic [7:0] f, lo, hi, op, fd);
    HOST.issue(f, lo, hi, op);
    HOST.rd(REG_OPCODE_FLAGS, s);
    check("state_flags", s, 16'h0061);
    HOST.rd(REG_FEATURE_FAULT, s);
    check("fault_detail", s, {8'h00, fd});
    HOST.rd(REG_DRIVE_SELECT, s);
    check("drive_select", s, 16'h0010);
    check("xfer_req", {15'h0000, XFER_REQ}, 16'h0000);
  endtask
  // ==========================================================
  // successful read of the structure
  task automatic expect_data(input logic a, input logic [2:0] st, input logic [3:0] r, input logic [15:0] sec);
    logic [7:0]  sum;
    logic [7:0]  eo;
    logic [15:0] es;
    int          n;
    @(posedge CLK);
    OFFLINE_AUTO    <= a;
    OFFLINE_STATE   <= st;
    TEST_RESULT     <= r;
    TEST_TENTHS     <= r;
    OFFLINE_SECONDS <= sec;
    HOST.issue(FEATURE_READ, KEY_LOW_VALUE, KEY_HIGH_VALUE, OPCODE_HEALTH);
    HOST.rd(REG_OPCODE_FLAGS, s);
    check("busy flags", s, 16'h0080);
    check("busy pin", {15'h0000, BUSY}, 16'h0001);
    HOST.wr(REG_KEY_LOW, 16'h0000);
    n = 0;
    while (XFER_REQ !== 1'b1 && n < 400)
    begin
      @(negedge CLK);
      n++;
    end
    HOST.rd(REG_OPCODE_FLAGS, s);
    check("transfer flags", s, 16'h0048);
    for (int i = 0; i < 256; i++)
    begin
      HOST.rd(REG_DATA, s);
      img[2*i]   = s[7:0];
      img[2*i+1] = s[15:8];
    end
    HOST.rd(REG_OPCODE_FLAGS, s);
    check("done flags", s, 16'h0040);
    HOST.rd(REG_FEATURE_FAULT, s);
    check("done fault_detail", s, 16'h0000);
    HOST.rd(REG_KEY_LOW, s);
    check("key_low kept", s, {8'h00, KEY_LOW_VALUE});
    check("xfer_req end", {15'h0000, XFER_REQ}, 16'h0000);
    case (st)
      3'h1: eo = 8'h02;
      3'h2: eo = 8'h04;
      3'h3: eo = 8'h05;
      3'h4: eo = 8'h06;
      default: eo = 8'h00;
    endcase
    es = (sec == 16'h0000) ? 16'h0001 : sec;
    checkb("offline status", 362, eo | {a, 7'h00});
    checkb("test status", 363, {(r > 4'h7 && r < 4'hf) ? 4'h0 : r, (r > 4'h9) ? 4'h9 : r});
    checkb("time low", 364, es[7:0]);
    checkb("time high", 365, es[15:8]);
    checkb("offline cap", 367, CAP_OFFLINE);
    checkb("cap low", 368, CAP_SMART[7:0]);
    checkb("cap high", 369, CAP_SMART[15:8]);
    checkb("errlog cap", 370, CAP_ERRLOG);
    checkb("short poll", 372, POLL_SHORT_MIN);
    checkb("ext poll", 373, POLL_EXT_MIN);
    for (int i = 374; i <= 385; i++) checkb("reserved", i, 8'h00);
    sum = 8'h00;
    for (int i = 0; i < 512; i++) sum = sum + img[i];
    check("checksum", {8'h00, sum}, 16'h0000);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    RST = 1'b1;
    SMART_ENABLED = 1'b1;
    PACKET_SET = 1'b0;
    DATA_UNFIXABLE = 1'b0;
    ID_MISSING = 1'b0;
    OFFLINE_AUTO = 1'b0;
    OFFLINE_STATE = 3'h0;
    TEST_RESULT = 4'h0;
    TEST_TENTHS = 4'h0;
    OFFLINE_SECONDS = 16'h0000;
    err_count = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    HOST.rd(REG_OPCODE_FLAGS, s);
    check("reset flags", s, 16'h0040);
    HOST.rd(REG_KEY_LOW, s);
    check("reset key_low", s, 16'h0000);
    HOST.rd(REG_DATA, s);
    check("idle data", s, 16'h0000);
    HOST.wr(REG_LOG_INDEX, 16'h0033);
    HOST.rd(REG_LOG_INDEX, s);
    check("log_index", s, 16'h0033);
    HOST.wr(REG_DRIVE_SELECT, 16'h0010);
    expect_error(8'hd5, KEY_LOW_VALUE, KEY_HIGH_VALUE, OPCODE_HEALTH, 8'h04);
    expect_error(FEATURE_READ, 8'h4e, KEY_HIGH_VALUE, OPCODE_HEALTH, 8'h04);
    expect_error(FEATURE_READ, KEY_LOW_VALUE, 8'hc3, OPCODE_HEALTH, 8'h04);
    expect_error(FEATURE_READ, KEY_LOW_VALUE, KEY_HIGH_VALUE, 8'hb1, 8'h04);
    HOST.rd(REG_BLOCK_COUNT, s);
    check("block_count", s, 16'h005a);
    SMART_ENABLED <= 1'b0;
    expect_error(FEATURE_READ, KEY_LOW_VALUE, KEY_HIGH_VALUE, OPCODE_HEALTH, 8'h04);
    SMART_ENABLED <= 1'b1;
    PACKET_SET <= 1'b1;
    expect_error(FEATURE_READ, KEY_LOW_VALUE, KEY_HIGH_VALUE, OPCODE_HEALTH, 8'h04);
    PACKET_SET <= 1'b0;
    DATA_UNFIXABLE <= 1'b1;
    expect_error(FEATURE_READ, KEY_LOW_VALUE, KEY_HIGH_VALUE, OPCODE_HEALTH, 8'h40);
    DATA_UNFIXABLE <= 1'b0;
    ID_MISSING <= 1'b1;
    expect_error(FEATURE_READ, KEY_LOW_VALUE, KEY_HIGH_VALUE, OPCODE_HEALTH, 8'h10);
    ID_MISSING <= 1'b0;
    for (int k = 0; k < 16; k++)
      expect_data(k[3], k[2:0], k[3:0], (k == 0) ? 16'h0000 : {k[3:0], 12'hfff});
    summarize();
  end
endmodule // test_health_read_cmd
bind health_read_cmd health_read_cmd_sva CHK (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .BUSY(BUSY), .XFER_REQ(XFER_REQ), .SMART_ENABLED(SMART_ENABLED),
  .PACKET_SET(PACKET_SET), .DATA_UNFIXABLE(DATA_UNFIXABLE), .ID_MISSING(ID_MISSING));
`default_nettype wire
